// [rtl/tap_pkg.sv]
// Constants, states and opcodes shared by the boundary scan test logic.
// Assumes one system clock that samples the test pins; no software access.
// Contract
// - Test logic is a state controller, instruction register and selected data registers.
// - Exactly three data registers: bypass, identification and boundary scan.
// - Bypass carries serial data whenever no other data register is accessed.
// - Identification register is 32 bits: lsb, identifier, part and version fields.
// - Boundary register has three cells per pin, serial and parallel in and out.
// - Controller is the standard sixteen-state machine in four state bits.
// - Transitions follow the test mode select level at each rising test clock edge.
// - Instruction states touch only the instruction register, data states only the selected one.
// - Controller derives all capture, shift and update controls from mode select and clock.
// - After power-up the controller sits in Test-Logic-Reset with no clock needed.
// - Five rising edges with mode select high always reach Test-Logic-Reset.
// - Test reset pin forces Test-Logic-Reset at once, without the test clock.
// - Decoder knows opcodes 00, 01, 05, 07, 0e, 0f and ff.
// - Boundary cells form one chain from data in to data out.
package tap_pkg;
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
		ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
		ST_PA_IR, ST_EX2_IR, ST_UPD_IR
	} tap_state_e;
	typedef enum logic [1:0] {SEL_BYPASS, SEL_IDENT, SEL_BOUND} dr_sel_e;
	localparam int IR_W = 8;
	localparam logic [7:0] OP_EXTEST = 8'h00;
	localparam logic [7:0] OP_SAMPLE = 8'h01;
	localparam logic [7:0] OP_CLAMP = 8'h05;
	localparam logic [7:0] OP_HIGHZ = 8'h07;
	localparam logic [7:0] OP_USERCODE = 8'h0e;
	localparam logic [7:0] OP_IDCODE = 8'h0f;
	localparam logic [7:0] OP_BYPASS = 8'hff;
	localparam logic [7:0] IR_CAPTURE = 8'h01;
	localparam int NUM_IO = 4;
	localparam int CELLS_PER_IO = 3;
	localparam int BSR_LEN = NUM_IO * CELLS_PER_IO;
	localparam int CELL_IN = 0;
	localparam int CELL_OUT = 1;
	localparam int CELL_OE = 2;
	// Identity fields; the values are arbitrary.
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART = 16'h0123;
	localparam logic [10:0] ID_MAKER = 11'h055;
	localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
	localparam logic [31:0] USER_VALUE = 32'h0000_0000;
	localparam logic [2:0] RESET_TMS_COUNT = 3'h5;
endpackage : tap_pkg

// [rtl/jtag_tap_boundary_scan.sv]
// Test access port with instruction register and three data registers.
// Assumes the test pins are asynchronous to mclk; tck runs far below mclk.
`timescale 1ns/1ps
module jtag_tap_boundary_scan
	import tap_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [NUM_IO-1:0] pad_in,
	input wire logic [NUM_IO-1:0] core_out,
	input wire logic [NUM_IO-1:0] core_oe,
	output logic [NUM_IO-1:0] pad_out,
	output logic [NUM_IO-1:0] pad_oe,
	output logic [NUM_IO-1:0] core_in
);
	function automatic dr_sel_e select_dr(input logic [IR_W-1:0] op);
		case (op)
			OP_IDCODE, OP_USERCODE: select_dr = SEL_IDENT;
			OP_EXTEST, OP_SAMPLE: select_dr = SEL_BOUND;
			default: select_dr = SEL_BYPASS;
		endcase
	endfunction : select_dr

	logic [2:0] tck_ff;
	logic [1:0] tms_ff, tdi_ff;
	logic [NUM_IO-1:0] pin_s1_ff, pin_s2_ff;
	logic tck_rise, tck_fall;
	tap_state_e state_ff, nxt_state;
	logic [IR_W-1:0] ir_ff, ir_sh_ff;
	logic byp_ff;
	logic [31:0] id_sh_ff;
	logic [BSR_LEN-1:0] bsr_sh_ff, bsr_upd_ff, cap_vec;
	dr_sel_e sel;
	logic tdo_src, in_shift;
	logic [2:0] tms_cnt_ff;
	logic [1:0] trst_sync_ff;
	logic any_rst;
	wire trst_clr = rst | ~trst_n;

	// The test reset pin clears the port at once; its release passes two
	// flops so that no register leaves reset close to a clock edge.
	always_ff @(posedge mclk or posedge trst_clr)
	begin
		if (trst_clr)
			trst_sync_ff <= 2'h0;
		else
			trst_sync_ff <= {trst_sync_ff[0], 1'b1};
	end
	assign any_rst = ~trst_sync_ff[1];

	// Only the second stage of each synchroniser feeds logic, except tck, whose second and third stages make the edge pulses.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tck_ff <= 3'h0;
			tms_ff <= 2'h3;
			tdi_ff <= 2'h3;
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end
		else
		begin
			tck_ff <= {tck_ff[1:0], tck};
			tms_ff <= {tms_ff[0], tms};
			tdi_ff <= {tdi_ff[0], tdi};
			pin_s1_ff <= pad_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end
	assign tck_rise = tck_ff[1] & ~tck_ff[2];
	assign tck_fall = ~tck_ff[1] & tck_ff[2];

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_TLR: nxt_state = tms_ff[1] ? ST_TLR : ST_RTI;
			ST_RTI: nxt_state = tms_ff[1] ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: nxt_state = tms_ff[1] ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: nxt_state = tms_ff[1] ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: nxt_state = tms_ff[1] ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: nxt_state = tms_ff[1] ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: nxt_state = tms_ff[1] ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: nxt_state = tms_ff[1] ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: nxt_state = tms_ff[1] ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: nxt_state = tms_ff[1] ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: nxt_state = tms_ff[1] ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: nxt_state = tms_ff[1] ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: nxt_state = tms_ff[1] ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: nxt_state = tms_ff[1] ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: nxt_state = tms_ff[1] ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: nxt_state = tms_ff[1] ? ST_SEL_DR : ST_RTI;
			default: nxt_state = ST_TLR;
		endcase
	end

	// The test reset pin acts straight on the state so it needs no clock.
	always_ff @(posedge mclk or posedge any_rst)
	begin
		if (any_rst)
			state_ff <= ST_TLR;
		else if (tck_rise)
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk or posedge any_rst)
	begin
		if (any_rst)
		begin
			ir_ff <= OP_IDCODE;
			ir_sh_ff <= IR_CAPTURE;
		end
		else if (state_ff == ST_TLR)
			ir_ff <= OP_IDCODE;
		else if (tck_rise)
		begin
			case (state_ff)
				ST_CAP_IR: ir_sh_ff <= IR_CAPTURE;
				ST_SH_IR: ir_sh_ff <= {tdi_ff[1], ir_sh_ff[IR_W-1:1]};
				ST_UPD_IR: ir_ff <= ir_sh_ff;
				default: ;
			endcase
		end
	end

	assign sel = select_dr(ir_ff);

	generate
		for (genvar i = 0; i < NUM_IO; i++)
		begin : g_cap
			assign cap_vec[CELLS_PER_IO*i+CELL_IN] = pin_s2_ff[i];
			assign cap_vec[CELLS_PER_IO*i+CELL_OUT] = core_out[i];
			assign cap_vec[CELLS_PER_IO*i+CELL_OE] = core_oe[i];
		end
	endgenerate

	always_ff @(posedge mclk or posedge any_rst)
	begin
		if (any_rst)
		begin
			byp_ff <= 1'b0;
			id_sh_ff <= ID_VALUE;
			bsr_sh_ff <= '0;
			bsr_upd_ff <= '0;
		end
		else if (tck_rise)
		begin
			case (sel)
				SEL_BYPASS:
				begin
					if (state_ff == ST_CAP_DR)
						byp_ff <= 1'b0;
					else if (state_ff == ST_SH_DR)
						byp_ff <= tdi_ff[1];
				end
				SEL_IDENT:
				begin
					if (state_ff == ST_CAP_DR)
						id_sh_ff <= (ir_ff == OP_IDCODE) ? ID_VALUE : USER_VALUE;
					else if (state_ff == ST_SH_DR)
						id_sh_ff <= {tdi_ff[1], id_sh_ff[31:1]};
				end
				default:
				begin
					if (state_ff == ST_CAP_DR)
						bsr_sh_ff <= cap_vec;
					else if (state_ff == ST_SH_DR)
						bsr_sh_ff <= {tdi_ff[1], bsr_sh_ff[BSR_LEN-1:1]};
					else if (state_ff == ST_UPD_DR)
						bsr_upd_ff <= bsr_sh_ff;
				end
			endcase
		end
	end

	always_comb
	begin
		in_shift = (state_ff == ST_SH_IR) || (state_ff == ST_SH_DR);
		if (state_ff == ST_SH_IR)
			tdo_src = ir_sh_ff[0];
		else if (sel == SEL_IDENT)
			tdo_src = id_sh_ff[0];
		else if (sel == SEL_BOUND)
			tdo_src = bsr_sh_ff[0];
		else
			tdo_src = byp_ff;
	end

	// Sampling on the falling edge gives the far end half a period of hold.
	always_ff @(posedge mclk or posedge any_rst)
	begin
		if (any_rst)
		begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo <= in_shift ? tdo_src : 1'b0;
			tdo_oe <= in_shift;
		end
	end

	// Pins follow the update stage under EXTEST and CLAMP; HIGHZ turns every pin driver off.
	generate
		for (genvar i = 0; i < NUM_IO; i++)
		begin : g_pin
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
				begin
					pad_out[i] <= 1'b0;
					pad_oe[i] <= 1'b0;
					core_in[i] <= 1'b0;
				end
				else
				begin
					if (ir_ff == OP_HIGHZ)
					begin
						pad_out[i] <= 1'b0;
						pad_oe[i] <= 1'b0;
					end
					else if (ir_ff == OP_EXTEST || ir_ff == OP_CLAMP)
					begin
						pad_out[i] <= bsr_upd_ff[CELLS_PER_IO*i+CELL_OUT];
						pad_oe[i] <= bsr_upd_ff[CELLS_PER_IO*i+CELL_OE];
					end
					else
					begin
						pad_out[i] <= core_out[i];
						pad_oe[i] <= core_oe[i];
					end
					core_in[i] <= (ir_ff == OP_EXTEST) ?
						bsr_upd_ff[CELLS_PER_IO*i+CELL_IN] : pin_s2_ff[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge any_rst)
	begin
		if (any_rst)
			tms_cnt_ff <= 3'h0;
		else if (tck_rise)
		begin
			if (!tms_ff[1])
				tms_cnt_ff <= 3'h0;
			else if (tms_cnt_ff != RESET_TMS_COUNT)
				tms_cnt_ff <= tms_cnt_ff + 3'h1;
		end
	end

	a_five_tms_reset: assert property (@(posedge mclk) disable iff (any_rst)
		(tms_cnt_ff == RESET_TMS_COUNT) |-> (state_ff == ST_TLR))
		else $error("Five high mode select edges did not reach reset.");
	a_state_on_edge: assert property (@(posedge mclk) disable iff (any_rst)
		!tck_rise |=> $stable(state_ff))
		else $error("State moved without a rising test clock.");
	a_tlr_exit: assert property (@(posedge mclk) disable iff (any_rst)
		(state_ff == ST_TLR && tck_rise && !tms_ff[1]) |=> (state_ff == ST_RTI))
		else $error("Low mode select did not leave reset for idle.");
	a_ir_update_load: assert property (@(posedge mclk) disable iff (any_rst)
		(state_ff == ST_UPD_IR && tck_rise) |=> (ir_ff == $past(ir_sh_ff)))
		else $error("Instruction did not load at update.");
	a_reset_idcode: assert property (@(posedge mclk) disable iff (any_rst)
		(state_ff == ST_TLR) |=> (ir_ff == OP_IDCODE))
		else $error("Reset did not select identification.");
	a_id_capture: assert property (@(posedge mclk) disable iff (any_rst)
		(state_ff == ST_CAP_DR && tck_rise && ir_ff == OP_IDCODE)
		|=> (id_sh_ff == ID_VALUE && id_sh_ff[0]))
		else $error("Identification capture wrong.");
	a_unknown_bypass: assert property (@(posedge mclk) disable iff (any_rst)
		(ir_ff != OP_EXTEST && ir_ff != OP_SAMPLE && ir_ff != OP_IDCODE &&
		ir_ff != OP_USERCODE) |-> (sel == SEL_BYPASS))
		else $error("Unsupported opcode did not pick bypass.");
	a_tdo_idle: assert property (@(posedge mclk) disable iff (any_rst)
		tck_fall |=> (tdo_oe == $past(in_shift)) && (tdo_oe || !tdo))
		else $error("Data out active outside shift.");
	a_highz_pins: assert property (@(posedge mclk) disable iff (rst)
		(ir_ff == OP_HIGHZ) |=> (pad_oe == '0))
		else $error("Pins driven under high impedance.");
	a_bypass_shift: assert property (@(posedge mclk) disable iff (any_rst)
		(state_ff == ST_SH_DR && tck_rise && sel == SEL_BYPASS)
		|=> (byp_ff == $past(tdi_ff[1])))
		else $error("Bypass did not take data in.");
endmodule : jtag_tap_boundary_scan

// [tb/jtag_host.sv]
// Behavioural test controller that drives the test pins of the device.
// Assumes mclk is the system clock; tck is built from it with a 200 ns period.
`timescale 1ns/1ps
module jtag_host
(
	input wire logic mclk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b1;
	end
	// Mode select and data are set in the low phase, well before the rise.
	// Outside a period the clock stands high and tdi rests at its pull-up.
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge mclk);
		#1;
		tck = 1'b0;
		tms = m;
		tdi = d;
		repeat (4) @(posedge mclk);
		#1;
		tck = 1'b1;
		repeat (2) @(posedge mclk);
		o = tdo;
		@(posedge mclk);
		#1;
		tdi = 1'b1;
	endtask : step
	task automatic reset5();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
	endtask : reset5
	// Starts and ends in Run-Test/Idle; bit i of dout is tdo while bit i shifts.
	task automatic scan(input logic ir, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir)
		begin
			step(1'b1, 1'b1, o);
		end
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : scan
	task automatic pulse_trst();
		@(posedge mclk);
		#1;
		trst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		trst_n = 1'b1;
		repeat (3) @(posedge mclk);
	endtask : pulse_trst
endmodule : jtag_host

// [tb/tb.sv]
// Self-checking bench for the test access port with a behavioural model.
// Assumes the host model owns the test pins; pin inputs are randomised here.
`timescale 1ns/1ps
module tb;
	import tap_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, o;
	logic [NUM_IO-1:0] pad_in = '0, core_out = '0, core_oe = '0;
	logic [NUM_IO-1:0] pad_out, pad_oe, core_in;
	int error_cnt = 0;
	int check_count = 0;
	int seed = 71513;
	int n;
	logic [31:0] din, dout;
	logic [BSR_LEN-1:0] upd = '0;
	logic [7:0] ops [8] = '{OP_SAMPLE, OP_EXTEST, OP_CLAMP, OP_HIGHZ,
		OP_USERCODE, OP_IDCODE, OP_BYPASS, 8'h3c};
	always #12.5 mclk = ~mclk;
	jtag_tap_boundary_scan jtag_tap_boundary_scan_inst (.mclk(mclk), .rst(rst),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out),
		.core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
		.core_in(core_in));
	jtag_host jtag_host_inst (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
		begin
			$display("STATUS OK");
		end
		else
		begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic idle_chk();
		repeat (2) @(posedge mclk);
		chk({30'h0, tdo_oe, tdo}, 32'h0);
	endtask : idle_chk
	task automatic ir_load(input logic [7:0] op);
		jtag_host_inst.scan(1'b1, {24'h0, op}, IR_W, dout);
		chk(dout, {24'h0, IR_CAPTURE});
	endtask : ir_load
	// The model: what shifts out of the selected register for this opcode.
	function automatic logic [31:0] exp_dr(input logic [7:0] op);
		logic [31:0] r;
		r = {din[19:0], 12'h0};
		for (int i = 0; i < NUM_IO; i++)
		begin
			r[3 * i] = pad_in[i];
			r[3 * i + 1] = core_out[i];
			r[3 * i + 2] = core_oe[i];
		end
		case (op)
			OP_SAMPLE, OP_EXTEST: return r;
			OP_USERCODE: return USER_VALUE;
			OP_IDCODE: return ID_VALUE;
			default: return {din[30:0], 1'b0};
		endcase
	endfunction : exp_dr
	function automatic logic [11:0] exp_pins(input logic [7:0] op);
		logic [3:0] eo, ee, ei;
		for (int i = 0; i < NUM_IO; i++)
		begin
			ei[i] = upd[3 * i];
			eo[i] = upd[3 * i + 1];
			ee[i] = upd[3 * i + 2];
		end
		if (op == OP_EXTEST)
			return {ee, eo, ei};
		if (op == OP_CLAMP)
			return {ee, eo, pad_in};
		if (op == OP_HIGHZ)
			return {4'h0, 4'h0, pad_in};
		return {core_oe, core_out, pad_in};
	endfunction : exp_pins
	initial
	begin
		repeat (90000) @(posedge mclk);
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge mclk);
		idle_chk();
		jtag_host_inst.step(1'b0, 1'b1, o);
		jtag_host_inst.scan(1'b0, 32'h0, 32, dout);
		chk(dout, ID_VALUE);
		$display("test reset_ident done");
		foreach (ops[k])
		begin
			@(posedge mclk);
			#1;
			pad_in = 4'($random(seed));
			core_out = 4'($random(seed));
			core_oe = 4'($random(seed));
			din = $random(seed);
			ir_load(ops[k]);
			jtag_host_inst.scan(1'b0, din, 32, dout);
			idle_chk();
			chk(dout, exp_dr(ops[k]));
			if (ops[k] == OP_SAMPLE || ops[k] == OP_EXTEST)
				upd = din[31:20];
			chk(32'({pad_oe, pad_out, core_in}), 32'(exp_pins(ops[k])));
		end
		$display("test opcode_table done");
		repeat (4)
		begin
			n = 1 + ($random(seed) & 15);
			repeat (n) jtag_host_inst.step(1'($random(seed)), 1'b1, o);
			jtag_host_inst.reset5();
			jtag_host_inst.step(1'b0, 1'b1, o);
			jtag_host_inst.scan(1'b0, 32'h0, 32, dout);
			chk(dout, ID_VALUE);
		end
		$display("test five_ones done");
		ir_load(OP_BYPASS);
		jtag_host_inst.step(1'b1, 1'b1, o);
		jtag_host_inst.step(1'b0, 1'b1, o);
		jtag_host_inst.step(1'b0, 1'b1, o);
		jtag_host_inst.step(1'b0, 1'b1, o);
		chk({30'h0, tdo_oe, tdo}, 32'h2);
		jtag_host_inst.pulse_trst();
		idle_chk();
		jtag_host_inst.step(1'b0, 1'b1, o);
		jtag_host_inst.scan(1'b0, 32'h0, 32, dout);
		chk(dout, ID_VALUE);
		$display("test trst done");
		report_and_stop();
	end
endmodule : tb
